// >>> design/sx_pkg.sv
// constants and field layouts of the shift/subtract/return/trap executor
// assumes a single 200 MHz processor clock and an outside decoder
//
// Functional notes
// - 3-bit selector picks Z C V N RA RE RX_BYTE_WAITING_FLAG TX_QUEUE_FULL_FLAG
// - return pops stacked address into program counter
// - return irq operand: keep, restore, set, clear
// - return restore operand reloads flags and banks
// - rotate right 0-7, lsb wraps, copied to carry
// - left shift 0-7, zero fill, carry last out
// - right shift 0-7, zero fill, carry last out
// - borrow subtract: src minus acc minus carry
// - accumulator subtract: src minus acc, all flags
// - immediate subtract on R0-R15, all flags
// - immediate xor on R0-R15, only N Z
// - accumulator xor to reg or memory, N Z
// - bank selection picks the active accumulator
// - trap pushes pc, irq enable, flags, banks
// - trap jumps to base concatenated with two zero bits and vector
// - trap clear operand 1 clears irq enable
// - trap vector ranges 0 to 63
// - hardware interrupts share fixed trap vectors
package sx_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 16;
   localparam int VEC_W = 6;
   localparam int DST_W = 5;
   // operation codes
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_GO_BACK = 4'h1;
   localparam logic [3:0] OP_ROT = 4'h2;
   localparam logic [3:0] OP_SHL = 4'h3;
   localparam logic [3:0] OP_SHR = 4'h4;
   localparam logic [3:0] OP_MINUS_BORROW = 4'h5;
   localparam logic [3:0] OP_MINUS_ACC = 4'h6;
   localparam logic [3:0] OP_SUB_IMM = 4'h7;
   localparam logic [3:0] OP_XOR_IMM = 4'h8;
   localparam logic [3:0] OP_XOR_ACC = 4'h9;
   localparam logic [3:0] OP_TRAP = 4'ha;
   // flag bit positions in the condition register
   localparam int FLG_Z = 0;
   localparam int FLG_C = 1;
   localparam int FLG_V = 2;
   localparam int FLG_N = 3;
   // return irq operand codes
   localparam logic [1:0] IRQ_KEEP = 2'h0;
   localparam logic [1:0] IRQ_RESTORE = 2'h1;
   localparam logic [1:0] IRQ_SET = 2'h2;
   localparam logic [1:0] IRQ_CLEAR = 2'h3;
   // shifter kinds
   localparam logic [1:0] SH_ROT = 2'h0;
   localparam logic [1:0] SH_LEFT = 2'h1;
   localparam logic [1:0] SH_RIGHT = 2'h2;
   // hardware interrupt vectors
   localparam logic [5:0] VEC_NMI = 6'h1c;
   localparam logic [5:0] VEC_RX = 6'h04;
   localparam logic [5:0] VEC_TX_EMPTY = 6'h08;
   localparam logic [5:0] VEC_TURNAROUND = 6'h0c;
   localparam logic [5:0] VEC_HOST_BUS = 6'h10;
   localparam logic [5:0] VEC_TIMER = 6'h14;
   // internal address stack
   localparam int STK_DEPTH = 12;
   localparam int STK_PTR_W = 4;
   localparam logic [STK_PTR_W-1:0] STK_LAST = 4'hb;
   // reset values
   localparam logic [PC_W-1:0] PC_RST = 16'h0000;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [1:0] BANK_RST = 2'h0;
   localparam logic IRQ_EN_RST = 1'b0;
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic irq_en;
      logic [3:0] flags;
      logic [1:0] bank;
   } sx_frame_type;
endpackage : sx_pkg

// >>> design/sx_shifter.sv
// barrel shifter for rotate, left shift and right shift
// assumes amount 0..7; zero amount leaves carry alone
`timescale 1ns/10ps
module sx_shifter
   import sx_pkg::*;
(
   input wire logic [DATA_W-1:0] i_value,
   input wire logic [2:0] i_amount,
   input wire logic [1:0] i_kind,
   input wire logic i_carry,
   output logic [DATA_W-1:0] o_result,
   output logic o_carry
);
   logic [2*DATA_W-1:0] wide;
   always_comb begin
      wide = '0;
      o_result = i_value;
      o_carry = i_carry;
      case (i_kind)
         SH_ROT: begin
            wide = {i_value, i_value} >> i_amount;
            o_result = wide[DATA_W-1:0];
            if (i_amount != 3'h0) begin
               o_carry = wide[DATA_W-1];
            end
         end
         SH_LEFT: begin
            wide = {8'h00, i_value} << i_amount;
            o_result = wide[DATA_W-1:0];
            if (i_amount != 3'h0) begin
               o_carry = wide[DATA_W];
            end
         end
         SH_RIGHT: begin
            wide = {i_value, 8'h00} >> i_amount;
            o_result = wide[2*DATA_W-1:DATA_W];
            if (i_amount != 3'h0) begin
               o_carry = wide[DATA_W-1];
            end
         end
         default: begin
            o_result = i_value;
         end
      endcase
   end
endmodule : sx_shifter

// >>> design/sx_subxor.sv
// subtract-with-borrow and exclusive-or datapath with flag results
// assumes flags ordered per the package bit positions
`timescale 1ns/10ps
module sx_subxor
   import sx_pkg::*;
(
   input wire logic [DATA_W-1:0] i_a,
   input wire logic [DATA_W-1:0] i_b,
   input wire logic i_borrow_in,
   input wire logic i_xor,
   output logic [DATA_W-1:0] o_result,
   output logic [3:0] o_flags
);
   logic [DATA_W:0] diff;
   always_comb begin
      diff = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_borrow_in};
      o_flags = '0;
      if (i_xor) begin
         o_result = i_a ^ i_b;
      end else begin
         o_result = diff[DATA_W-1:0];
         o_flags[FLG_C] = diff[DATA_W];
         o_flags[FLG_V] = (i_a[7] != i_b[7]) && (o_result[7] != i_a[7]);
      end
      o_flags[FLG_Z] = (o_result == 8'h00);
      o_flags[FLG_N] = o_result[7];
   end
endmodule : sx_subxor

// >>> design/sx_exec.sv
// executor for return, rotate, shifts, subtracts, xors and trap
// assumes an outside decoder presents one instruction per i_valid pulse,
// the register file supplies operands and takes o_result on o_wr_reg/o_wr_mem
`timescale 1ns/10ps
module sx_exec
   import sx_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire logic [3:0] i_op,
   input wire logic [2:0] i_flag_sel,
   input wire logic [1:0] i_irq_op,
   input wire logic i_restore,
   input wire logic i_trap_clear,
   input wire logic [VEC_W-1:0] i_vector,
   input wire logic [2:0] i_amount,
   input wire logic [DATA_W-1:0] i_src,
   input wire logic [DATA_W-1:0] i_imm,
   input wire logic [DST_W-1:0] i_dst_idx,
   input wire logic i_dst_mem,
   input wire logic [DATA_W-1:0] i_acc_main,
   input wire logic [DATA_W-1:0] i_acc_alt,
   input wire logic [DATA_W-1:0] i_vector_base,
   input wire logic i_bank_wr,
   input wire logic [1:0] i_bank_val,
   input wire logic i_rx_active,
   input wire logic i_rx_fault,
   input wire logic i_rx_byte_waiting,
   input wire logic i_tx_queue_full,
   output logic [DATA_W-1:0] o_result,
   output logic [DST_W-1:0] o_dst_idx,
   output logic o_wr_reg,
   output logic o_wr_mem,
   output logic [3:0] o_flags,
   output logic o_master_irq_enable,
   output logic [1:0] o_bank_sel,
   output logic [PC_W-1:0] o_pc,
   output logic o_flag_test,
   output logic [STK_PTR_W-1:0] o_stack_ptr
);
   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   function automatic logic [STK_PTR_W-1:0] ptr_inc(input logic [STK_PTR_W-1:0] p);
      ptr_inc = (p == STK_LAST) ? '0 : p + 4'h1;
   endfunction : ptr_inc

   function automatic logic [STK_PTR_W-1:0] ptr_dec(input logic [STK_PTR_W-1:0] p);
      ptr_dec = (p == '0) ? STK_LAST : p - 4'h1;
   endfunction : ptr_dec

   // --------------------------------------------------------------
   // transceiver status synchroniser
   // --------------------------------------------------------------
   logic [3:0] sync1_reg;
   logic [3:0] sync1_next;
   logic [3:0] sync2_reg;
   logic [3:0] sync2_next;

   always_comb begin
      sync1_next = {i_tx_queue_full, i_rx_byte_waiting, i_rx_fault, i_rx_active};
      sync2_next = sync1_reg;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   // --------------------------------------------------------------
   // datapath
   // --------------------------------------------------------------
   logic [3:0] flags_reg;
   logic [3:0] flags_next;
   logic irq_en_reg;
   logic irq_en_next;
   logic [1:0] bank_reg;
   logic [1:0] bank_next;
   logic [PC_W-1:0] pc_reg;
   logic [PC_W-1:0] pc_next;
   logic [STK_PTR_W-1:0] sp_reg;
   logic [STK_PTR_W-1:0] sp_next;
   sx_frame_type stack_reg [STK_DEPTH];
   sx_frame_type push_frame;
   sx_frame_type top_frame;
   logic push_en;

   logic [DATA_W-1:0] active_acc;
   logic [DATA_W-1:0] alu_a;
   logic [DATA_W-1:0] alu_b;
   logic alu_borrow;
   logic alu_xor;
   logic [DATA_W-1:0] alu_result;
   logic [3:0] alu_flags;
   logic [1:0] sh_kind;
   logic [DATA_W-1:0] sh_result;
   logic sh_carry;

   assign active_acc = bank_reg[0] ? i_acc_alt : i_acc_main;
   assign top_frame = stack_reg[ptr_dec(sp_reg)];

   always_comb begin
      alu_a = i_src;
      alu_b = active_acc;
      alu_borrow = 1'b0;
      alu_xor = 1'b0;
      sh_kind = SH_ROT;
      case (i_op)
         OP_MINUS_BORROW: begin
            alu_borrow = flags_reg[FLG_C];
         end
         OP_SUB_IMM: begin
            alu_b = i_imm;
         end
         OP_XOR_IMM: begin
            alu_b = i_imm;
            alu_xor = 1'b1;
         end
         OP_XOR_ACC: begin
            alu_xor = 1'b1;
         end
         OP_SHL: begin
            sh_kind = SH_LEFT;
         end
         OP_SHR: begin
            sh_kind = SH_RIGHT;
         end
         default: begin
            alu_borrow = 1'b0;
         end
      endcase
   end

   sx_subxor u_subxor (
      .i_a(alu_a),
      .i_b(alu_b),
      .i_borrow_in(alu_borrow),
      .i_xor(alu_xor),
      .o_result(alu_result),
      .o_flags(alu_flags)
   );

   sx_shifter u_shifter (
      .i_value(i_src),
      .i_amount(i_amount),
      .i_kind(sh_kind),
      .i_carry(flags_reg[FLG_C]),
      .o_result(sh_result),
      .o_carry(sh_carry)
   );

   // --------------------------------------------------------------
   // execution state
   // --------------------------------------------------------------
   logic [DATA_W-1:0] result_reg;
   logic [DATA_W-1:0] result_next;
   logic [DST_W-1:0] dst_reg;
   logic [DST_W-1:0] dst_next;
   logic wr_reg_reg;
   logic wr_reg_next;
   logic wr_mem_reg;
   logic wr_mem_next;
   logic test_reg;
   logic test_next;
   logic [7:0] test_src;

   always_comb begin
      test_src = {sync2_reg, flags_reg[FLG_N], flags_reg[FLG_V], flags_reg[FLG_C], flags_reg[FLG_Z]};
      test_next = test_src[i_flag_sel];
      flags_next = flags_reg;
      irq_en_next = irq_en_reg;
      bank_next = bank_reg;
      pc_next = pc_reg;
      sp_next = sp_reg;
      push_en = 1'b0;
      push_frame = '{pc: pc_reg + 16'h0001, irq_en: irq_en_reg, flags: flags_reg, bank: bank_reg};
      result_next = result_reg;
      dst_next = dst_reg;
      wr_reg_next = 1'b0;
      wr_mem_next = 1'b0;
      if (i_bank_wr) begin
         bank_next = i_bank_val;
      end
      if (i_valid) begin
         pc_next = pc_reg + 16'h0001;
         dst_next = i_dst_idx;
         case (i_op)
            OP_GO_BACK: begin
               pc_next = top_frame.pc;
               sp_next = ptr_dec(sp_reg);
               case (i_irq_op)
                  IRQ_RESTORE: irq_en_next = top_frame.irq_en;
                  IRQ_SET: irq_en_next = 1'b1;
                  IRQ_CLEAR: irq_en_next = 1'b0;
                  default: irq_en_next = irq_en_reg;
               endcase
               if (i_restore) begin
                  flags_next = top_frame.flags;
                  bank_next = top_frame.bank;
               end
            end
            OP_ROT, OP_SHL, OP_SHR: begin
               result_next = sh_result;
               wr_reg_next = 1'b1;
               flags_next[FLG_C] = sh_carry;
               flags_next[FLG_Z] = (sh_result == 8'h00);
               flags_next[FLG_N] = sh_result[7];
            end
            OP_MINUS_BORROW, OP_MINUS_ACC: begin
               result_next = alu_result;
               wr_reg_next = !i_dst_mem;
               wr_mem_next = i_dst_mem;
               flags_next = alu_flags;
            end
            OP_SUB_IMM: begin
               result_next = alu_result;
               dst_next = {1'b0, i_dst_idx[3:0]};
               wr_reg_next = 1'b1;
               flags_next = alu_flags;
            end
            OP_XOR_IMM: begin
               result_next = alu_result;
               dst_next = {1'b0, i_dst_idx[3:0]};
               wr_reg_next = 1'b1;
               flags_next[FLG_Z] = alu_flags[FLG_Z];
               flags_next[FLG_N] = alu_flags[FLG_N];
            end
            OP_XOR_ACC: begin
               result_next = alu_result;
               wr_reg_next = !i_dst_mem;
               wr_mem_next = i_dst_mem;
               flags_next[FLG_Z] = alu_flags[FLG_Z];
               flags_next[FLG_N] = alu_flags[FLG_N];
            end
            OP_TRAP: begin
               push_en = 1'b1;
               sp_next = ptr_inc(sp_reg);
               pc_next = {i_vector_base, 2'b00, i_vector};
               if (i_trap_clear) begin
                  irq_en_next = 1'b0;
               end
            end
            default: begin
               pc_next = pc_reg + 16'h0001;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         flags_reg <= FLAGS_RST;
         irq_en_reg <= IRQ_EN_RST;
         bank_reg <= BANK_RST;
         pc_reg <= PC_RST;
         sp_reg <= '0;
         result_reg <= 8'h00;
         dst_reg <= '0;
         wr_reg_reg <= 1'b0;
         wr_mem_reg <= 1'b0;
         test_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         irq_en_reg <= irq_en_next;
         bank_reg <= bank_next;
         pc_reg <= pc_next;
         sp_reg <= sp_next;
         result_reg <= result_next;
         dst_reg <= dst_next;
         wr_reg_reg <= wr_reg_next;
         wr_mem_reg <= wr_mem_next;
         test_reg <= test_next;
      end
   end

   // --------------------------------------------------------------
   // internal address stack
   // --------------------------------------------------------------
   sx_frame_type stack_next [STK_DEPTH];

   always_comb begin
      for (int k = 0; k < STK_DEPTH; k++) begin
         stack_next[k] = stack_reg[k];
      end
      if (push_en) begin
         stack_next[sp_reg] = push_frame;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int k = 0; k < STK_DEPTH; k++) begin
            stack_reg[k] <= '0;
         end
      end else begin
         for (int k = 0; k < STK_DEPTH; k++) begin
            stack_reg[k] <= stack_next[k];
         end
      end
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   assign o_result = result_reg;
   assign o_dst_idx = dst_reg;
   assign o_wr_reg = wr_reg_reg;
   assign o_wr_mem = wr_mem_reg;
   assign o_flags = flags_reg;
   assign o_master_irq_enable = irq_en_reg;
   assign o_bank_sel = bank_reg;
   assign o_pc = pc_reg;
   assign o_flag_test = test_reg;
   assign o_stack_ptr = sp_reg;
endmodule : sx_exec

// >>> tb/sx_exec_properties.sv
// port-level assertions for the shift/subtract/return/trap executor
// assumes binding into sx_exec; one clock, asynchronous active-low reset
`timescale 1ns/10ps
module sx_exec_properties
   import sx_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire logic [3:0] i_op,
   input wire logic [1:0] i_irq_op,
   input wire logic i_restore,
   input wire logic i_trap_clear,
   input wire logic [VEC_W-1:0] i_vector,
   input wire logic i_dst_mem,
   input wire logic [DATA_W-1:0] i_vector_base,
   input wire logic i_bank_wr,
   input wire logic [DATA_W-1:0] o_result,
   input wire logic [DST_W-1:0] o_dst_idx,
   input wire logic o_wr_reg,
   input wire logic o_wr_mem,
   input wire logic [3:0] o_flags,
   input wire logic o_master_irq_enable,
   input wire logic [1:0] o_bank_sel,
   input wire logic [PC_W-1:0] o_pc,
   input wire logic [STK_PTR_W-1:0] o_stack_ptr
);
   logic trap_go;
   logic ret_go;
   logic res_go;
   logic imm_go;
   logic xor_go;
   logic mem_ok;
   assign trap_go = i_valid && i_op == OP_TRAP;
   assign ret_go = i_valid && i_op == OP_GO_BACK;
   assign res_go = i_valid && i_op >= OP_ROT && i_op <= OP_XOR_ACC;
   assign imm_go = i_valid && (i_op == OP_SUB_IMM || i_op == OP_XOR_IMM);
   assign xor_go = i_valid && (i_op == OP_XOR_IMM || i_op == OP_XOR_ACC);
   assign mem_ok = i_op == OP_MINUS_BORROW || i_op == OP_MINUS_ACC || i_op == OP_XOR_ACC;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   trap_target_a: assert property (trap_go |=> o_pc == {$past(i_vector_base), 2'b00, $past(i_vector)})
      else $error("trap target wrong");
   trap_push_a: assert property (trap_go |=> o_stack_ptr == (($past(o_stack_ptr) == STK_LAST) ? 4'h0 : $past(o_stack_ptr) + 4'h1))
      else $error("trap push wrong");
   ret_pop_a: assert property (ret_go |=> o_stack_ptr == (($past(o_stack_ptr) == 4'h0) ? STK_LAST : $past(o_stack_ptr) - 4'h1))
      else $error("return pop wrong");
   trap_keep_a: assert property (trap_go && !i_bank_wr |=> $stable(o_flags) && $stable(o_bank_sel))
      else $error("trap changed flags");
   trap_clear_a: assert property (trap_go && i_trap_clear |=> !o_master_irq_enable)
      else $error("trap did not clear irq enable");
   ret_irq_a: assert property (ret_go && i_irq_op[1] |=> o_master_irq_enable == !$past(i_irq_op[0]))
      else $error("return irq set or clear wrong");
   ret_norestore_a: assert property (ret_go && !i_restore |=> $stable(o_flags))
      else $error("return changed flags");
   nz_result_a: assert property (res_go |=> o_flags[FLG_N] == o_result[7] && o_flags[FLG_Z] == (o_result == 8'h00))
      else $error("n or z flag wrong");
   xor_cv_a: assert property (xor_go |=> $stable(o_flags[FLG_C]) && $stable(o_flags[FLG_V]))
      else $error("xor touched c or v");
   imm_dst_a: assert property (imm_go |=> o_wr_reg && !o_wr_mem && !o_dst_idx[DST_W-1])
      else $error("immediate destination wrong");
   wr_mem_a: assert property (o_wr_mem |-> $past(i_valid && i_dst_mem && mem_ok))
      else $error("memory write without cause");
   trap_cov: cover property (trap_go && i_trap_clear);
   restore_cov: cover property (ret_go && i_restore && i_irq_op == IRQ_RESTORE);
   mem_cov: cover property (i_valid && i_op == OP_MINUS_BORROW && i_dst_mem);
endmodule : sx_exec_properties

bind sx_exec sx_exec_properties u_props (.i_clk, .i_resetn, .i_valid, .i_op, .i_irq_op, .i_restore,
   .i_trap_clear, .i_vector, .i_dst_mem, .i_vector_base, .i_bank_wr, .o_result, .o_dst_idx, .o_wr_reg,
   .o_wr_mem, .o_flags, .o_master_irq_enable, .o_bank_sel, .o_pc, .o_stack_ptr);

// >>> tb/testbench.sv
// self-checking bench comparing the executor with a behavioural model
// assumes sx_exec with its checker bound; 200 MHz clock
`timescale 1ns/10ps
module testbench
   import sx_pkg::*;
;
   logic i_clk;
   logic i_resetn;
   logic i_valid;
   logic i_restore;
   logic i_trap_clear;
   logic i_dst_mem;
   logic i_bank_wr;
   logic [3:0] i_tr;
   logic [3:0] i_op;
   logic [2:0] i_flag_sel;
   logic [2:0] i_amount;
   logic [1:0] i_irq_op;
   logic [1:0] i_bank_val;
   logic [VEC_W-1:0] i_vector;
   logic [DATA_W-1:0] i_src;
   logic [DATA_W-1:0] i_imm;
   logic [DATA_W-1:0] i_acc_main;
   logic [DATA_W-1:0] i_acc_alt;
   logic [DATA_W-1:0] i_vector_base;
   logic [DST_W-1:0] i_dst_idx;
   logic [DATA_W-1:0] o_result;
   logic [DST_W-1:0] o_dst_idx;
   logic o_wr_reg;
   logic o_wr_mem;
   logic o_master_irq_enable;
   logic o_flag_test;
   logic [3:0] o_flags;
   logic [1:0] o_bank_sel;
   logic [PC_W-1:0] o_pc;
   logic [STK_PTR_W-1:0] o_stack_ptr;
   logic [7:0] m_res = 8'h00;
   logic [4:0] m_dst = 5'h00;
   logic m_wr = 1'b0;
   logic m_wm = 1'b0;
   logic m_ie = 1'b0;
   logic [3:0] m_fl = 4'h0;
   logic [1:0] m_bk = 2'h0;
   logic [15:0] m_pc = 16'h0000;
   int m_sp = 0;
   sx_frame_type m_stk [STK_DEPTH];
   logic [5:0] vecs [7] = '{VEC_NMI, VEC_RX, VEC_TX_EMPTY, VEC_TURNAROUND, VEC_HOST_BUS, VEC_TIMER, 6'h3f};
   int seed = 44;
   int n_mismatch = 0;
   int n_tests = 0;
   int i;
   int j;

   sx_exec dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_valid(i_valid), .i_op(i_op), .i_flag_sel(i_flag_sel),
      .i_irq_op(i_irq_op), .i_restore(i_restore), .i_trap_clear(i_trap_clear), .i_vector(i_vector),
      .i_amount(i_amount), .i_src(i_src), .i_imm(i_imm), .i_dst_idx(i_dst_idx), .i_dst_mem(i_dst_mem),
      .i_acc_main(i_acc_main), .i_acc_alt(i_acc_alt), .i_vector_base(i_vector_base), .i_bank_wr(i_bank_wr),
      .i_bank_val(i_bank_val), .i_rx_active(i_tr[0]), .i_rx_fault(i_tr[1]), .i_rx_byte_waiting(i_tr[2]),
      .i_tx_queue_full(i_tr[3]), .o_result(o_result), .o_dst_idx(o_dst_idx), .o_wr_reg(o_wr_reg),
      .o_wr_mem(o_wr_mem), .o_flags(o_flags), .o_master_irq_enable(o_master_irq_enable),
      .o_bank_sel(o_bank_sel), .o_pc(o_pc), .o_flag_test(o_flag_test), .o_stack_ptr(o_stack_ptr));

   // ------------------------------------------------------------
   // checking and model
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_all();
      chk({o_result, o_dst_idx, o_wr_reg, o_wr_mem, o_flags, o_master_irq_enable, o_bank_sel, o_pc, o_stack_ptr},
         {m_res, m_dst, m_wr, m_wm, m_fl, m_ie, m_bk, m_pc, 4'(m_sp)});
   endtask : chk_all

   task automatic issue(input logic [3:0] op, input logic [5:0] vec, input logic [1:0] irq, input logic rst,
      input logic clr);
      logic [8:0] d;
      logic [7:0] r;
      logic [7:0] b;
      logic [7:0] acc;
      logic [7:0] src;
      logic [7:0] imm;
      logic [7:0] am;
      logic [7:0] aa;
      logic [7:0] vb;
      logic [4:0] dst;
      logic [2:0] amt;
      logic [1:0] bv;
      logic mem;
      logic bw;
      logic c;
      sx_frame_type f;
      src = $random(seed);
      imm = $random(seed);
      am = $random(seed);
      aa = $random(seed);
      vb = $random(seed);
      dst = $random(seed);
      amt = $random(seed);
      bv = $random(seed);
      mem = $random(seed);
      bw = ($random(seed) & 3) == 0;
      @(posedge i_clk);
      i_valid <= 1'b1;
      i_op <= op;
      i_vector <= vec;
      i_irq_op <= irq;
      i_restore <= rst;
      i_trap_clear <= clr;
      i_src <= src;
      i_imm <= imm;
      i_acc_main <= am;
      i_acc_alt <= aa;
      i_vector_base <= vb;
      i_dst_idx <= dst;
      i_amount <= amt;
      i_dst_mem <= mem;
      i_bank_wr <= bw;
      i_bank_val <= bv;
      acc = m_bk[0] ? aa : am;
      r = src;
      c = m_fl[FLG_C];
      case (op)
         OP_ROT, OP_SHL, OP_SHR: begin
            for (int k = 0; k < amt; k++) begin
               c = (op == OP_SHL) ? r[7] : r[0];
               r = (op == OP_SHL) ? {r[6:0], 1'b0} : {(op == OP_ROT) & r[0], r[7:1]};
            end
            m_fl[FLG_C] = c;
         end
         OP_MINUS_BORROW, OP_MINUS_ACC, OP_SUB_IMM: begin
            b = (op == OP_SUB_IMM) ? imm : acc;
            d = {1'b0, src} - {1'b0, b} - 9'((op == OP_MINUS_BORROW) & c);
            r = d[7:0];
            m_fl[FLG_C] = d[8];
            m_fl[FLG_V] = (src[7] != b[7]) && (r[7] != src[7]);
         end
         OP_XOR_IMM, OP_XOR_ACC: r = src ^ ((op == OP_XOR_IMM) ? imm : acc);
         OP_TRAP: begin
            m_stk[m_sp] = {m_pc + 16'h0001, m_ie, m_fl, m_bk};
            m_sp = (m_sp + 1) % STK_DEPTH;
            m_pc = {vb, 2'b00, vec};
            if (clr) m_ie = 1'b0;
         end
         OP_GO_BACK: begin
            m_sp = (m_sp + STK_DEPTH - 1) % STK_DEPTH;
            f = m_stk[m_sp];
            m_pc = f.pc;
            if (irq == IRQ_RESTORE) m_ie = f.irq_en;
            if (irq[1]) m_ie = !irq[0];
            if (rst) begin
               m_fl = f.flags;
               m_bk = f.bank;
            end
         end
         default: ;
      endcase
      m_wr = 1'b0;
      m_wm = 1'b0;
      m_dst = (op == OP_SUB_IMM || op == OP_XOR_IMM) ? {1'b0, dst[3:0]} : dst;
      if (op != OP_TRAP && op != OP_GO_BACK) m_pc = m_pc + 16'h0001;
      if (op >= OP_ROT && op <= OP_XOR_ACC) begin
         m_res = r;
         m_fl[FLG_N] = r[7];
         m_fl[FLG_Z] = (r == 8'h00);
         m_wm = mem && (op == OP_MINUS_BORROW || op == OP_MINUS_ACC || op == OP_XOR_ACC);
         m_wr = !m_wm;
      end
      if (bw && !(op == OP_GO_BACK && rst)) m_bk = bv;
      @(posedge i_clk);
      i_valid <= 1'b0;
      i_bank_wr <= 1'b0;
      #1;
      chk_all();
   endtask : issue

   task automatic flag_scan();
      logic [3:0] tr;
      tr = $random(seed);
      for (int s = 0; s < 8; s++) begin
         @(posedge i_clk);
         i_tr <= tr;
         i_flag_sel <= 3'(s);
         repeat (4) @(posedge i_clk);
         #1;
         chk(o_flag_test, (s < 4) ? m_fl[s] : tr[s-4]);
      end
   endtask : flag_scan

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   initial begin
      repeat (50000) @(posedge i_clk);
      n_mismatch++;
      finish_test();
   end

   initial begin
      {i_resetn, i_valid, i_restore, i_trap_clear, i_dst_mem, i_bank_wr, i_tr, i_op, i_flag_sel} = '0;
      {i_amount, i_irq_op, i_bank_val, i_vector, i_src, i_imm, i_acc_main, i_acc_alt} = '0;
      {i_vector_base, i_dst_idx} = '0;
      for (i = 0; i < STK_DEPTH; i++) m_stk[i] = '0;
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'b1;
      #1;
      chk_all();
      flag_scan();
      for (i = 0; i < 160; i++) issue(4'(i % 8 + 2), 6'h00, 2'h0, 1'b0, 1'b0);
      flag_scan();
      for (j = 0; j < 2; j++) begin
         issue(OP_TRAP, 6'h00, 2'h0, 1'b0, 1'b0);
         issue(OP_GO_BACK, 6'h00, IRQ_SET, 1'b0, 1'b0);
         issue(OP_NOP, 6'h00, 2'h0, 1'b0, 1'b0);
         for (i = 0; i < 7; i++) begin
            issue(OP_TRAP, vecs[i], 2'h0, 1'b0, i[0]);
            issue(OP_MINUS_ACC, 6'h00, 2'h0, 1'b0, 1'b0);
         end
         for (i = 0; i < 7; i++) issue(OP_GO_BACK, 6'h00, i[1:0], i[1] ^ j[0], 1'b0);
      end
      finish_test();
   end
endmodule : testbench
